/* smt_map.svh */
`ifndef SMT_MAP_SVH
`define SMT_MAP_SVH
// Address field positions of the 24-bit logical address (bit 0 unused).
`define SMT_PAGE_LSB 9
`define SMT_PAGE_MSB 16
`define SMT_SEG_LSB 17
`define SMT_SEG_MSB 23
`define SMT_REGSEL_BIT 3
`define SMT_ROM_SEL_BIT 15
`define SMT_ROM_DESEL_BIT 16
// Register RAM geometry.
`define SMT_RAM_DEPTH 1024
`define SMT_RAM_WIDTH 12
`define SMT_SEG_COUNT 128
`define SMT_CONTEXTS 4
// Limit register fields.
`define SMT_LIMIT_COUNT_MSB 7
`define SMT_TYPE_LSB 8
// Supervisor context.
`define SMT_SUPER_CONTEXT 2'h0
// Origin value of block zero.
`define SMT_ORIGIN_ZERO 12'h000
// Timing: master clock period and processor clock period.
`define SMT_MASTER_NS 50
`define SMT_CPU_CLK_NS 200
`define SMT_SYS_NS 20
`define SMT_MASTER_DIV ((`SMT_MASTER_NS + `SMT_SYS_NS - 1) / `SMT_SYS_NS)
// Timing states.
`define SMT_T3 3'h3
`define SMT_T7 3'h7
// Segment type codes in the limit register's upper nibble.
`define SMT_TYPE_MEM_BIT 0
`define SMT_TYPE_IO_BIT 1
`define SMT_TYPE_RO_BIT 2
`define SMT_TYPE_STK_BIT 3
`endif

/* smt_pkg.sv */
package smt_pkg;
   typedef enum logic [1:0] {
      smt_space_mem,
      smt_space_io,
      smt_space_special
   } smt_space_t;
   typedef enum {
      smt_idle,
      smt_origin,
      smt_limit
   } smt_phase_t;
endpackage

/* smt_ram_if.sv */
`timescale 1ns/1ps
interface smt_ram_if #(parameter int AW = 10, parameter int DW = 12);
   logic [AW-1:0] addr;
   logic wr_en;
   logic [DW-1:0] wr_data;
   logic [DW-1:0] rd_data;
   modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
   modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface

/* smt_reg_ram.sv */
`timescale 1ns/1ps
module smt_reg_ram
   import smt_pkg::*;
#(
   parameter int DEPTH = 1024,
   parameter int WIDTH = 12
) (
   input wire logic clock,
   smt_ram_if.mem port
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // No reset: contents stay undefined until software writes them.
   logic [WIDTH-1:0] cells [DEPTH];
   logic [WIDTH-1:0] next_rd;

   if (DEPTH != 1024 || WIDTH != 12) begin : g_bad_geometry
      $error("smt_reg_ram geometry not supported");
   end

   always_comb begin
      next_rd = cells[port.addr];
   end

   always_ff @(posedge clock) begin
      if (port.wr_en) begin
         cells[port.addr] <= port.wr_data;
      end
      port.rd_data <= next_rd;
   end
endmodule

/* smt_segment_mmu.sv */
`timescale 1ns/1ps
`include "smt_map.svh"
// Operation
// - 512-byte pages, 128K segments, low bits pass.
// - Bits 17-23 segment, bits 9-16 page.
// - Four register sets chosen by context lines.
// - Origin is 12 bits, 512-byte blocks.
// - Limit holds page count plus type code.
// - Limit counts in 512-byte pages.
// - Memory, I/O, special I/O spaces.
// - One 1Kx12 RAM, writable in any mode.
// - RAM address: segment, context, select bit.
// - Latch enable sets when strobe drops.
// - Latch enable clears at video t7 end.
// - Supervisor function code overrides software context.
// - Boot ROM on special I/O, bit15 high, bit16 low.
// - Master and pixel ticks come every 3 clocks, 60 ns.
// - Counter decodes eight states plus video half.
// - Counter second bit is a 12-clock, 240 ns clock.
// - Supervisor forces context 0 except register access.
// - Adder overflow flags out-of-range access, inverted for stack segments.
module smt_segment_mmu
   import smt_pkg::*;
#(
   parameter int SEG_BITS = 7,
   parameter int PAGE_BITS = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Processor side
   input wire logic [23:1] logical_addr,
   input wire logic addr_strobe,
   input wire logic read_cycle,
   input wire logic supervisor_function_code,
   input wire logic context_select_0,
   input wire logic context_select_1,
   // Register access data
   input wire logic [11:0] reg_wr_data,
   output logic [11:0] reg_rd_data,
   // Timing outputs
   output logic master_timing_clock,
   output logic pixel_shift_clock,
   output logic distributed_system_clock,
   output logic timing_state_first_n,
   output logic timing_state_last_n,
   output logic [2:0] timing_state,
   output logic video_half,
   output logic first_processor_cycle,
   // Translation outputs
   output logic addr_latch_enable,
   output logic [20:9] phys_addr,
   output logic [8:1] phys_low_addr,
   output logic [1:0] phys_space,
   output logic read_only_seg,
   output logic stack_seg,
   output logic limit_overflow_flag,
   output logic special_io_cycle,
   output logic boot_rom_enable
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // The field slices below are written for these widths; other values would cut addresses silently.
   if (SEG_BITS != 7 || PAGE_BITS != 8) begin : g_bad_fields
      $error("smt_segment_mmu supports 7 segment and 8 page bits only");
   end
   // The divider counter is two bits wide.
   if (`SMT_MASTER_DIV < 2 || `SMT_MASTER_DIV > 4) begin : g_bad_divider
      $error("smt_segment_mmu master divider out of range");
   end

   // ----------------------------------------
   // Timing counter
   // ----------------------------------------
   // The system clock is faster than the 50 ns master period; an enable pulse stands in for each master edge.
   logic [1:0] div_cnt;
   logic [1:0] next_div_cnt;
   logic master_tick;
   logic [3:0] tcount;
   logic [3:0] next_tcount;

   always_comb begin
      master_tick = (div_cnt == 2'(`SMT_MASTER_DIV - 1));
      next_div_cnt = master_tick ? 2'h0 : div_cnt + 2'h1;
      next_tcount = master_tick ? tcount + 4'h1 : tcount;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 2'h0;
         tcount <= 4'h0;
      end else begin
         div_cnt <= next_div_cnt;
         tcount <= next_tcount;
      end
   end

   always_comb begin
      master_timing_clock = master_tick;
      pixel_shift_clock = master_tick;
      timing_state = tcount[2:0];
      video_half = ~tcount[3];
      timing_state_first_n = ~(tcount[2:0] == 3'h0);
      timing_state_last_n = ~(tcount[2:0] == `SMT_T7);
      distributed_system_clock = tcount[1];
   end

   // ----------------------------------------
   // Context and register access decode
   // ----------------------------------------
   logic reg_access;
   logic [1:0] map_context;
   logic select_origin;
   logic [9:0] ram_addr;
   logic strobe_q;
   logic t7_video_end;

   always_comb begin
      reg_access = addr_strobe && logical_addr[`SMT_ROM_SEL_BIT] && !logical_addr[`SMT_ROM_DESEL_BIT]
                   && special_io_cycle;
      boot_rom_enable = reg_access;
      if (supervisor_function_code && !reg_access) begin
         map_context = `SMT_SUPER_CONTEXT;
      end else begin
         map_context = {context_select_1, context_select_0};
      end
      if (reg_access) begin
         select_origin = ~logical_addr[`SMT_REGSEL_BIT];
      end else begin
         select_origin = addr_latch_enable;
      end
      ram_addr = {logical_addr[`SMT_SEG_MSB:`SMT_SEG_LSB], map_context, ~select_origin};
      t7_video_end = master_tick && video_half && (tcount[2:0] == `SMT_T7);
   end

   smt_ram_if #(.AW(10), .DW(`SMT_RAM_WIDTH)) ram_bus ();

   assign ram_bus.addr = ram_addr;
   assign ram_bus.wr_en = reg_access && !read_cycle && master_tick && (tcount[2:0] == `SMT_T3);
   assign ram_bus.wr_data = reg_wr_data;

   smt_reg_ram #(.DEPTH(`SMT_RAM_DEPTH), .WIDTH(`SMT_RAM_WIDTH)) u_ram (
      .clock(clock),
      .port(ram_bus)
   );

   // ----------------------------------------
   // Latch enable and cycle flag
   // ----------------------------------------
   // The register RAM answers one clock after its address moves, so the origin word is only trusted once the
   // latch enable has stood for two clocks. A clear that comes earlier waits for the next video t7.
   logic next_ale;
   logic next_first_cycle;
   logic next_reg_cycle;
   logic next_check;
   logic ale_q;
   logic reg_q;
   logic reg_cycle;
   logic check_step;
   logic strobe_end;
   logic origin_ready;

   always_comb begin
      strobe_end = strobe_q && !addr_strobe;
      origin_ready = addr_latch_enable && ale_q;
      next_ale = addr_latch_enable;
      next_reg_cycle = reg_cycle;
      next_first_cycle = first_processor_cycle;
      if (t7_video_end && origin_ready) begin
         next_ale = 1'b0;
      end
      // A strobe that ends in the clearing cycle still starts its own latch phase, so the set wins.
      if (strobe_end) begin
         next_ale = 1'b1;
         next_reg_cycle = reg_q;
      end
      if (t7_video_end) begin
         next_first_cycle = 1'b1;
      end else if (master_tick && !video_half && tcount[2:0] == `SMT_T7) begin
         next_first_cycle = 1'b0;
      end
      // The limit word reaches the RAM output one clock after the latch enable falls.
      next_check = ale_q && !addr_latch_enable && !reg_cycle;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strobe_q <= 1'b0;
         reg_q <= 1'b0;
         addr_latch_enable <= 1'b0;
         ale_q <= 1'b0;
         reg_cycle <= 1'b0;
         check_step <= 1'b0;
         first_processor_cycle <= 1'b0;
      end else begin
         strobe_q <= addr_strobe;
         reg_q <= reg_access;
         addr_latch_enable <= next_ale;
         ale_q <= addr_latch_enable;
         reg_cycle <= next_reg_cycle;
         check_step <= next_check;
         first_processor_cycle <= next_first_cycle;
      end
   end

   // ----------------------------------------
   // Translation
   // ----------------------------------------
   // A register access also runs a latch phase, but its results are dropped: otherwise the words of a set
   // that software is still filling in would overwrite the last translation.
   logic [11:0] next_phys;
   logic [11:0] ram_q;
   logic [12:0] origin_sum;

   always_comb begin
      ram_q = ram_bus.rd_data;
      // Origin counts 512-byte blocks; page bits add into its low byte, upper nibble of page is zero.
      origin_sum = {1'b0, ram_q} + {5'h00, logical_addr[`SMT_PAGE_MSB:`SMT_PAGE_LSB]};
      next_phys = phys_addr;
      if (addr_latch_enable && !next_ale && !reg_cycle) begin
         next_phys = origin_sum[11:0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         phys_addr <= `SMT_ORIGIN_ZERO;
         phys_low_addr <= 8'h00;
      end else begin
         phys_addr <= next_phys;
         phys_low_addr <= logical_addr[8:1];
      end
   end

   // ----------------------------------------
   // Limit check and segment type
   // ----------------------------------------
   // The special I/O flag leaves reset set: until a limit word has been read every cycle counts as special
   // I/O, so the boot ROM and the register RAM are reachable before any register holds a defined value.
   logic [1:0] next_space;
   logic next_ro;
   logic next_stk;
   logic next_overflow;
   logic next_special;
   logic [8:0] limit_sum;
   logic [3:0] type_code;
   logic limit_phase;

   always_comb begin
      limit_phase = check_step;
      type_code = ram_q[11:`SMT_TYPE_LSB];
      limit_sum = {1'b0, ram_q[`SMT_LIMIT_COUNT_MSB:0]}
                  + {1'b0, logical_addr[`SMT_PAGE_MSB:`SMT_PAGE_LSB]};
      next_space = phys_space;
      next_ro = read_only_seg;
      next_stk = stack_seg;
      next_overflow = limit_overflow_flag;
      next_special = special_io_cycle;
      if (limit_phase) begin
         next_overflow = limit_sum[8] ^ type_code[`SMT_TYPE_STK_BIT];
         next_ro = type_code[`SMT_TYPE_RO_BIT];
         next_stk = type_code[`SMT_TYPE_STK_BIT];
         if (type_code[`SMT_TYPE_MEM_BIT]) begin
            next_space = smt_space_mem;
         end else if (type_code[`SMT_TYPE_IO_BIT]) begin
            next_space = smt_space_io;
         end else begin
            next_space = smt_space_special;
         end
         next_special = !type_code[`SMT_TYPE_MEM_BIT] && !type_code[`SMT_TYPE_IO_BIT];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         phys_space <= smt_space_special;
         read_only_seg <= 1'b0;
         stack_seg <= 1'b0;
         limit_overflow_flag <= 1'b0;
         special_io_cycle <= 1'b1;
      end else begin
         phys_space <= next_space;
         read_only_seg <= next_ro;
         stack_seg <= next_stk;
         limit_overflow_flag <= next_overflow;
         special_io_cycle <= next_special;
      end
   end

   // ----------------------------------------
   // Register readback
   // ----------------------------------------
   logic [11:0] next_rd_data;

   always_comb begin
      next_rd_data = reg_rd_data;
      if (reg_access && read_cycle) begin
         next_rd_data = ram_q;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rd_data <= 12'h000;
      end else begin
         reg_rd_data <= next_rd_data;
      end
   end
endmodule

/* smt_segment_mmu_chk.sv */
`timescale 1ns/1ps
module smt_segment_mmu_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Processor side
   input wire logic [23:1] logical_addr,
   input wire logic addr_strobe,
   // Timing and translation
   input wire logic master_timing_clock,
   input wire logic pixel_shift_clock,
   input wire logic distributed_system_clock,
   input wire logic timing_state_first_n,
   input wire logic timing_state_last_n,
   input wire logic [2:0] timing_state,
   input wire logic first_processor_cycle,
   input wire logic addr_latch_enable,
   input wire logic [8:1] phys_low_addr,
   input wire logic [1:0] phys_space,
   input wire logic special_io_cycle,
   input wire logic boot_rom_enable
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   a_tick_every_three: assert property (master_timing_clock |=> !master_timing_clock ##1
      !master_timing_clock ##1 master_timing_clock) else $error("master tick spacing wrong");
   a_pixel_tick_rate: assert property (pixel_shift_clock |-> ##3 pixel_shift_clock)
      else $error("pixel tick spacing wrong");
   a_first_state_decode: assert property (timing_state_first_n == (timing_state != 3'h0))
      else $error("first state decode wrong");
   a_last_state_decode: assert property (timing_state_last_n == (timing_state != 3'h7))
      else $error("last state decode wrong");
   // A 12-clock period is too long to unroll as a repetition, so the clocks between rises are counted.
   logic sys_clk_q;
   logic sys_rise_seen;
   logic [3:0] sys_gap;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sys_clk_q <= 1'b0;
         sys_rise_seen <= 1'b0;
         sys_gap <= 4'h0;
      end else begin
         sys_clk_q <= distributed_system_clock;
         if (distributed_system_clock && !sys_clk_q) begin
            sys_rise_seen <= 1'b1;
            sys_gap <= 4'h1;
         end else if (sys_gap != 4'hF) begin
            sys_gap <= sys_gap + 4'h1;
         end
      end
   end
   a_sys_clock_period: assert property (distributed_system_clock && !sys_clk_q && sys_rise_seen |->
      sys_gap == 4'hC) else $error("system clock period wrong");
   a_ale_on_strobe: assert property ($fell(addr_strobe) |=> addr_latch_enable)
      else $error("latch enable missing after strobe");
   a_ale_with_cycle: assert property ($fell(addr_latch_enable) |-> first_processor_cycle)
      else $error("latch enable cleared apart from cycle flag");
   a_low_bits_pass: assert property ($past(arst_n) |-> phys_low_addr == $past(logical_addr[8:1]))
      else $error("low address bits altered");
   a_rom_decode: assert property (boot_rom_enable == (addr_strobe && logical_addr[15] &&
      !logical_addr[16] && special_io_cycle)) else $error("rom enable decode wrong");
   a_space_legal: assert property (phys_space != 2'h3)
      else $error("undefined space code");
   c_translate: cover property ($fell(addr_latch_enable));
   c_rom: cover property ($rose(boot_rom_enable));
   c_first_cycle: cover property ($rose(first_processor_cycle));
endmodule

/* smt_cpu_model.sv */
`timescale 1ns/1ps
module smt_cpu_model (
   // Bus
   input wire logic clock,
   input wire logic [11:0] reg_rd_data,
   output logic [23:1] logical_addr,
   output logic addr_strobe,
   output logic read_cycle,
   output logic [11:0] reg_wr_data
);
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   initial begin
      logical_addr = 23'h0;
      addr_strobe = 1'b0;
      read_cycle = 1'b1;
      reg_wr_data = 12'h000;
   end
   // The address is held after the strobe drops, since the limit check still uses it.
   task automatic bus_cycle(input logic [23:1] a, input logic rd, output logic [11:0] q);
      @(negedge clock);
      logical_addr = a;
      read_cycle = rd;
      addr_strobe = 1'b1;
      repeat (59) @(negedge clock);
      q = reg_rd_data;
      @(negedge clock);
      addr_strobe = 1'b0;
      repeat (60) @(negedge clock);
   endtask
   task automatic reg_access(input logic [6:0] seg, input logic lim, input logic rd, input logic [11:0] d,
                             output logic [11:0] q);
      reg_wr_data = d;
      bus_cycle({seg, 8'h40, 5'h00, lim, 2'h0}, rd, q);
      bus_cycle({seg, 8'h40, 5'h00, lim, 2'h0}, rd, q);
   endtask
endmodule

/* smt_segment_mmu_tb.sv */
`timescale 1ns/1ps
module smt_segment_mmu_tb;
   import smt_pkg::*;
   localparam logic [11:0] ORG [4] = '{12'h0A0, 12'h123, 12'h456, 12'h789};
   logic clock, arst_n, addr_strobe, read_cycle, supervisor_function_code, context_select_0;
   logic context_select_1, master_timing_clock, pixel_shift_clock, distributed_system_clock;
   logic timing_state_first_n, timing_state_last_n, video_half, first_processor_cycle;
   logic addr_latch_enable, read_only_seg, stack_seg, limit_overflow_flag, special_io_cycle, boot_rom_enable;
   logic [23:1] logical_addr;
   logic [11:0] reg_wr_data, reg_rd_data, phys_addr;
   logic [2:0] timing_state;
   logic [8:1] phys_low_addr;
   logic [1:0] phys_space;
   int failures = 0;
   int samples_checked = 0;
   smt_segment_mmu i_smt_segment_mmu (.clock, .arst_n, .logical_addr, .addr_strobe, .read_cycle,
      .supervisor_function_code, .context_select_0, .context_select_1, .reg_wr_data, .reg_rd_data,
      .master_timing_clock, .pixel_shift_clock, .distributed_system_clock, .timing_state_first_n,
      .timing_state_last_n, .timing_state, .video_half, .first_processor_cycle, .addr_latch_enable,
      .phys_addr, .phys_low_addr, .phys_space, .read_only_seg, .stack_seg, .limit_overflow_flag,
      .special_io_cycle, .boot_rom_enable);
   smt_cpu_model i_smt_cpu_model (.clock, .reg_rd_data, .logical_addr, .addr_strobe, .read_cycle,
      .reg_wr_data);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic set_ctx(input logic [1:0] c, input logic s);
      @(negedge clock);
      context_select_0 = c[0];
      context_select_1 = c[1];
      supervisor_function_code = s;
   endtask
   task automatic xlate(input logic [7:0] pg, input logic [11:0] org, input logic [11:0] lim,
                        input smt_space_t sp);
      logic [11:0] q;
      logic [8:0] sum;
      sum = {1'b0, pg} + {1'b0, lim[7:0]};
      i_smt_cpu_model.bus_cycle({7'h05, pg, 8'h00}, 1'b1, q);
      check("phys", phys_addr, org + {4'h0, pg});
      check("space", {10'h0, phys_space}, {10'h0, sp});
      check("overflow", {11'h0, limit_overflow_flag}, {11'h0, sum[8]});
      check("read_only", {11'h0, read_only_seg}, {11'h0, lim[10]});
      check("stack", {11'h0, stack_seg}, {11'h0, lim[11]});
      check("special", {11'h0, special_io_cycle}, {11'h0, lim[9:8] == 2'h0});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      repeat (16) @(negedge clock);
      check("ale", {11'h0, addr_latch_enable}, 12'h000);
      check("phys", phys_addr, 12'h000);
      check("special", {11'h0, special_io_cycle}, 12'h001);
      arst_n = 1'b1;
   endtask
   task automatic t_timing();
      logic [2:0] prev;
      logic half;
      int gap;
      prev = timing_state;
      half = video_half;
      gap = 0;
      for (int n = 0; n < 20;) begin
         @(negedge clock);
         gap++;
         if (timing_state !== prev) begin
            check("state", {9'h0, timing_state}, {9'h0, prev + 3'h1});
            if (n > 0) check("gap", gap[11:0], 12'h003);
            check("half", {11'h0, video_half}, {11'h0, half ^ (timing_state == 3'h0)});
            check("sysclk", {11'h0, distributed_system_clock}, {11'h0, timing_state[1]});
            half = video_half;
            prev = timing_state;
            gap = 0;
            n++;
         end
      end
   endtask
   // Context 3 is written in supervisor mode, which must not redirect a register access.
   task automatic t_regs();
      logic [11:0] q;
      for (int c = 0; c < 4; c++) begin
         set_ctx(c[1:0], c == 3);
         i_smt_cpu_model.reg_access(7'h05, 1'b0, 1'b0, ORG[c], q);
      end
      for (int c = 0; c < 4; c++) begin
         set_ctx(c[1:0], 1'b0);
         i_smt_cpu_model.reg_access(7'h05, 1'b0, 1'b1, 12'h000, q);
         check("origin", q, ORG[c]);
      end
      set_ctx(2'h1, 1'b0);
      i_smt_cpu_model.reg_access(7'h05, 1'b1, 1'b0, 12'h120, q);
      set_ctx(2'h0, 1'b0);
      i_smt_cpu_model.reg_access(7'h05, 1'b1, 1'b0, 12'h2F0, q);
   endtask
   task automatic t_xlate();
      set_ctx(2'h1, 1'b0);
      // Page 25 keeps address bit 15 low, so the cycle is not taken as a register access while special I/O stands.
      xlate(8'h25, ORG[1], 12'h120, smt_space_mem);
      xlate(8'hE5, ORG[1], 12'h120, smt_space_mem);
   endtask
   task automatic t_super();
      set_ctx(2'h1, 1'b1);
      xlate(8'h10, ORG[0], 12'h2F0, smt_space_io);
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      arst_n = 1'b0;
      supervisor_function_code = 1'b0;
      context_select_0 = 1'b0;
      context_select_1 = 1'b0;
      t_reset();
      t_timing();
      t_regs();
      t_xlate();
      t_super();
      end_sim();
   end
   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule
bind smt_segment_mmu smt_segment_mmu_chk i_smt_segment_mmu_chk (.clock, .arst_n, .logical_addr,
   .addr_strobe, .master_timing_clock, .pixel_shift_clock, .distributed_system_clock, .timing_state_first_n,
   .timing_state_last_n, .timing_state, .first_processor_cycle, .addr_latch_enable, .phys_low_addr,
   .phys_space, .special_io_cycle, .boot_rom_enable);
